// >>> core/crfhl_regfile.sv
// General register array with two reads, one write and the result pair
`timescale 1ns/10ps
`default_nettype none
`include "crfhl_params.svh"
// Overview of operation
// - Thirty-two general registers, sixty-four bits each, picked by five-bit index.
// - Index zero always reads zero; writes to it are dropped.
// - Link writes go to index thirty-one implicitly; otherwise ordinary register.
// - Every write is sixty-four bits; thirty-two-bit results are sign-extended first.
// - Separate upper and lower result words receive multiply products.
// - Multiply-add and multiply-subtract load the combined result into the pair.
// - Divide puts quotient in lower word, remainder in upper word.
// - Multiply-accumulate leaves the running total in the pair.
// - No program counter port; it is not addressable here.
// - Operand sizes byte, halfword, word and doubleword are handled.
// - Other registers carry no implied function.
module crfhl_regfile import crfhl_pkg::*; (
   // Clock, reset, enable
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // Read port A
   input wire logic [`CRFHL_IDX_W-1:0] i_rd_a_idx,
   output logic [`CRFHL_DATA_W-1:0] o_rd_a_data,
   // Read port B
   input wire logic [`CRFHL_IDX_W-1:0] i_rd_b_idx,
   output logic [`CRFHL_DATA_W-1:0] o_rd_b_data,
   // Write port
   input wire logic i_wr_en,
   input wire logic i_wr_link,
   input wire logic [`CRFHL_IDX_W-1:0] i_wr_idx,
   input wire crfhl_size_t i_wr_size,
   input wire logic i_wr_signed,
   input wire logic [`CRFHL_DATA_W-1:0] i_wr_data,
   // Result pair update
   input wire crfhl_resop_t i_res_op,
   input wire logic [`CRFHL_DATA_W-1:0] i_res_top,
   input wire logic [`CRFHL_DATA_W-1:0] i_res_bot,
   output logic [`CRFHL_DATA_W-1:0] o_result_top_word,
   output logic [`CRFHL_DATA_W-1:0] o_result_bottom_word
);
   logic [`CRFHL_DATA_W-1:0] general_register_array [`CRFHL_NUM_REGS];
   logic [`CRFHL_DATA_W-1:0] next_array [`CRFHL_NUM_REGS];
   logic [`CRFHL_IDX_W-1:0] wr_target;
   logic [`CRFHL_DATA_W-1:0] wr_value;
   logic [`CRFHL_DATA_W-1:0] rd_a;
   logic [`CRFHL_DATA_W-1:0] rd_b;
   logic [`CRFHL_DATA_W-1:0] next_rd_a;
   logic [`CRFHL_DATA_W-1:0] next_rd_b;

   // Width conversion of the incoming result
   always_comb begin
      wr_target = i_wr_link ? `CRFHL_LINK_IDX : i_wr_idx;
      case (i_wr_size)
         CRFHL_SZ_BYTE: wr_value = i_wr_signed ? {{(`CRFHL_DATA_W-`CRFHL_BYTE_W){i_wr_data[`CRFHL_BYTE_W-1]}},
                                                  i_wr_data[`CRFHL_BYTE_W-1:0]}
                                               : {{(`CRFHL_DATA_W-`CRFHL_BYTE_W){1'h0}}, i_wr_data[`CRFHL_BYTE_W-1:0]};
         CRFHL_SZ_HALF: wr_value = i_wr_signed ? {{(`CRFHL_DATA_W-`CRFHL_HWORD_W){i_wr_data[`CRFHL_HWORD_W-1]}},
                                                  i_wr_data[`CRFHL_HWORD_W-1:0]}
                                               : {{(`CRFHL_DATA_W-`CRFHL_HWORD_W){1'h0}}, i_wr_data[`CRFHL_HWORD_W-1:0]};
         CRFHL_SZ_WORD: wr_value = {{`CRFHL_HALF_W{i_wr_data[`CRFHL_HALF_W-1]}},
                                    i_wr_data[`CRFHL_HALF_W-1:0]};
         CRFHL_SZ_DOUBLE: wr_value = i_wr_data;
         default: wr_value = i_wr_data;
      endcase
   end

   // One storage word per index; index zero never stored
   generate
      for (genvar g = 0; g < `CRFHL_NUM_REGS; g++) begin : g_reg
         localparam logic [`CRFHL_IDX_W-1:0] SLOT_IDX = `CRFHL_IDX_W'(g);
         always_comb begin
            next_array[g] = general_register_array[g];
            if (g == 0) begin
               next_array[g] = `CRFHL_ZERO_DATA;
            end else if (i_wr_en && wr_target == SLOT_IDX) begin
               next_array[g] = wr_value;
            end
         end
         always_ff @(posedge i_sys_clk) begin
            if (i_rst) begin
               general_register_array[g] <= `CRFHL_ZERO_DATA;
            end else if (i_ce) begin
               general_register_array[g] <= next_array[g];
            end
         end
      end
   endgenerate

   // Registered reads see state written in earlier cycles only
   always_comb begin
      next_rd_a = (i_rd_a_idx == `CRFHL_ZERO_IDX) ? `CRFHL_ZERO_DATA
                                                  : general_register_array[i_rd_a_idx];
      next_rd_b = (i_rd_b_idx == `CRFHL_ZERO_IDX) ? `CRFHL_ZERO_DATA
                                                  : general_register_array[i_rd_b_idx];
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         rd_a <= `CRFHL_ZERO_DATA;
         rd_b <= `CRFHL_ZERO_DATA;
      end else if (i_ce) begin
         rd_a <= next_rd_a;
         rd_b <= next_rd_b;
      end
   end

   assign o_rd_a_data = rd_a;
   assign o_rd_b_data = rd_b;

   // Program counter is deliberately absent from this block
   crfhl_result_pair u_pair (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_op(i_res_op),
      .i_top(i_res_top),
      .i_bot(i_res_bot),
      .o_result_top_word(o_result_top_word),
      .o_result_bottom_word(o_result_bottom_word)
   );

   chk_zero_reads: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      i_ce && i_rd_a_idx == `CRFHL_ZERO_IDX |=> o_rd_a_data == `CRFHL_ZERO_DATA)
      else $error("zero index read nonzero");
   chk_write_visible: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      i_ce && i_wr_en && !i_wr_link && i_wr_idx != `CRFHL_ZERO_IDX && i_wr_size == CRFHL_SZ_DOUBLE
      ##1 i_ce && i_rd_b_idx == $past(i_wr_idx) && !(i_wr_en && i_wr_idx == $past(i_wr_idx))
      |=> o_rd_b_data == $past(i_wr_data, 2))
      else $error("write not visible next cycle");
   chk_link_target: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      i_ce && i_wr_en && i_wr_link |=> general_register_array[`CRFHL_LINK_IDX] == $past(wr_value))
      else $error("link write missed");
   chk_word_sext: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      i_wr_size == CRFHL_SZ_WORD
      |-> wr_value[`CRFHL_DATA_W-1:`CRFHL_HALF_W] == {`CRFHL_HALF_W{i_wr_data[`CRFHL_HALF_W-1]}})
      else $error("word not sign-extended");
   chk_mul_pair: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      i_ce && i_res_op == CRFHL_RES_MUL |=> o_result_top_word == $past(i_res_top)
      && o_result_bottom_word == $past(i_res_bot))
      else $error("product not stored");
   chk_div_pair: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      i_ce && i_res_op == CRFHL_RES_DIV |=> o_result_bottom_word == $past(i_res_bot))
      else $error("quotient misplaced");
   chk_pair_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      !i_ce || i_res_op == CRFHL_RES_NONE |=> $stable(o_result_top_word) && $stable(o_result_bottom_word))
      else $error("pair changed without op");
   chk_madd_pair: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      i_ce && (i_res_op == CRFHL_RES_MADD || i_res_op == CRFHL_RES_MSUB)
      |=> o_result_top_word == $past(i_res_top))
      else $error("combined result lost");

   // Multi-step checks: a full-width write, then a read of the same slot
   sequence s_dbl_write;
      i_ce && i_wr_en && !i_wr_link && i_wr_idx != `CRFHL_ZERO_IDX && i_wr_size == CRFHL_SZ_DOUBLE;
   endsequence
   sequence s_read_a_back;
      i_ce && i_rd_a_idx == $past(i_wr_idx);
   endsequence
   sequence s_link_write;
      i_ce && i_wr_en && i_wr_link && i_wr_size == CRFHL_SZ_DOUBLE;
   endsequence
   sequence s_read_a_link;
      i_ce && i_rd_a_idx == `CRFHL_LINK_IDX;
   endsequence
   chk_zero_reads_b: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      i_ce && i_rd_b_idx == `CRFHL_ZERO_IDX
      |=> o_rd_b_data == `CRFHL_ZERO_DATA)
      else $error("zero index read nonzero on port b");
   chk_write_visible_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      s_dbl_write ##1 s_read_a_back
      |=> o_rd_a_data == $past(i_wr_data, 2))
      else $error("write not visible on port a");
   chk_link_value: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      s_link_write ##1 s_read_a_link
      |=> o_rd_a_data == $past(i_wr_data, 2))
      else $error("link value not readable");
   chk_zero_sink: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      i_ce
      |=> general_register_array[`CRFHL_ZERO_IDX] == `CRFHL_ZERO_DATA)
      else $error("zero slot holds data");
   chk_byte_sext: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      i_wr_size == CRFHL_SZ_BYTE && i_wr_signed
      |-> $signed(wr_value) == $signed(i_wr_data[`CRFHL_BYTE_W-1:0]))
      else $error("byte not sign-extended");
   chk_byte_zext: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      i_wr_size == CRFHL_SZ_BYTE && !i_wr_signed
      |-> wr_value == i_wr_data[`CRFHL_BYTE_W-1:0])
      else $error("byte not zero-extended");
   chk_half_sext: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      i_wr_size == CRFHL_SZ_HALF && i_wr_signed
      |-> $signed(wr_value) == $signed(i_wr_data[`CRFHL_HWORD_W-1:0]))
      else $error("halfword not sign-extended");
   chk_half_zext: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      i_wr_size == CRFHL_SZ_HALF && !i_wr_signed
      |-> wr_value == i_wr_data[`CRFHL_HWORD_W-1:0])
      else $error("halfword not zero-extended");
   chk_double_pass: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      i_wr_size == CRFHL_SZ_DOUBLE
      |-> wr_value == i_wr_data)
      else $error("doubleword altered");
   chk_madd_bottom: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      i_ce && (i_res_op == CRFHL_RES_MADD || i_res_op == CRFHL_RES_MSUB)
      |=> o_result_bottom_word == $past(i_res_bot))
      else $error("combined low word lost");
   chk_div_top: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      i_ce && i_res_op == CRFHL_RES_DIV
      |=> o_result_top_word == $past(i_res_top))
      else $error("remainder misplaced");
   chk_macc_pair: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      i_ce && i_res_op == CRFHL_RES_MACC
      |=> o_result_top_word == $past(i_res_top) && o_result_bottom_word == $past(i_res_bot))
      else $error("running total lost");
   chk_settop_only: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      i_ce && i_res_op == CRFHL_RES_SETTOP
      |=> o_result_top_word == $past(i_res_top) && $stable(o_result_bottom_word))
      else $error("top load disturbed bottom");
   chk_setbot_only: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      i_ce && i_res_op == CRFHL_RES_SETBOT
      |=> o_result_bottom_word == $past(i_res_bot) && $stable(o_result_top_word))
      else $error("bottom load disturbed top");
   chk_rd_freeze: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      !i_ce
      |=> $stable(o_rd_a_data) && $stable(o_rd_b_data))
      else $error("read data moved while frozen");
   chk_reset_clear: assert property (@(posedge i_sys_clk)
      i_rst |=> o_rd_a_data == `CRFHL_ZERO_DATA && o_rd_b_data == `CRFHL_ZERO_DATA
      && o_result_top_word == `CRFHL_ZERO_DATA && o_result_bottom_word == `CRFHL_ZERO_DATA)
      else $error("outputs not cleared by reset");
endmodule : crfhl_regfile
`default_nettype wire

// >>> common/crfhl_params.svh
// Constants for the register file and result pair
`ifndef CRFHL_PARAMS_SVH
`define CRFHL_PARAMS_SVH
`define CRFHL_NUM_REGS 32
`define CRFHL_DATA_W 64
`define CRFHL_IDX_W 5
`define CRFHL_HALF_W 32
`define CRFHL_BYTE_W 8
`define CRFHL_HWORD_W 16
`define CRFHL_ZERO_IDX 5'h00
`define CRFHL_LINK_IDX 5'h1f
`define CRFHL_ZERO_DATA 64'h0000_0000_0000_0000
`define CRFHL_SIZE_W 2
`define CRFHL_OP_W 3
`endif

// >>> common/crfhl_pkg.sv
// Types for the register file and result pair
package crfhl_pkg;
   typedef enum logic [1:0] {
      CRFHL_SZ_BYTE,
      CRFHL_SZ_HALF,
      CRFHL_SZ_WORD,
      CRFHL_SZ_DOUBLE
   } crfhl_size_t;
   typedef enum logic [2:0] {
      CRFHL_RES_NONE,
      CRFHL_RES_MUL,
      CRFHL_RES_MADD,
      CRFHL_RES_MSUB,
      CRFHL_RES_DIV,
      CRFHL_RES_MACC,
      CRFHL_RES_SETTOP,
      CRFHL_RES_SETBOT
   } crfhl_resop_t;
endpackage : crfhl_pkg

// >>> core/crfhl_result_pair.sv
// Upper and lower result word pair for multiply, divide and accumulate
`timescale 1ns/10ps
`default_nettype none
`include "crfhl_params.svh"
module crfhl_result_pair import crfhl_pkg::*; (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // Result update
   input wire crfhl_resop_t i_op,
   input wire logic [`CRFHL_DATA_W-1:0] i_top,
   input wire logic [`CRFHL_DATA_W-1:0] i_bot,
   // State
   output logic [`CRFHL_DATA_W-1:0] o_result_top_word,
   output logic [`CRFHL_DATA_W-1:0] o_result_bottom_word
);
   logic [`CRFHL_DATA_W-1:0] result_top_word;
   logic [`CRFHL_DATA_W-1:0] result_bottom_word;
   logic [`CRFHL_DATA_W-1:0] next_result_top_word;
   logic [`CRFHL_DATA_W-1:0] next_result_bottom_word;

   always_comb begin
      next_result_top_word = result_top_word;
      next_result_bottom_word = result_bottom_word;
      case (i_op)
         CRFHL_RES_MUL, CRFHL_RES_MADD, CRFHL_RES_MSUB, CRFHL_RES_MACC: begin
            // Pipeline delivers the full combined or accumulated value
            next_result_top_word = i_top;
            next_result_bottom_word = i_bot;
         end
         CRFHL_RES_DIV: begin
            // Remainder on top, quotient on bottom
            next_result_top_word = i_top;
            next_result_bottom_word = i_bot;
         end
         CRFHL_RES_SETTOP: next_result_top_word = i_top;
         CRFHL_RES_SETBOT: next_result_bottom_word = i_bot;
         CRFHL_RES_NONE: next_result_top_word = result_top_word;
         default: next_result_top_word = result_top_word;
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         result_top_word <= `CRFHL_ZERO_DATA;
         result_bottom_word <= `CRFHL_ZERO_DATA;
      end else if (i_ce) begin
         result_top_word <= next_result_top_word;
         result_bottom_word <= next_result_bottom_word;
      end
   end

   assign o_result_top_word = result_top_word;
   assign o_result_bottom_word = result_bottom_word;
endmodule : crfhl_result_pair
`default_nettype wire

// >>> bench/crfhl_pipe_model.sv
// Pipeline model that computes the values loaded into the result pair
`timescale 1ns/10ps
`default_nettype none
module crfhl_pipe_model import crfhl_pkg::*; (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // Operation and operands
   input wire crfhl_resop_t i_op,
   input wire logic [63:0] i_a,
   input wire logic [63:0] i_b,
   // Pair values to load
   output logic [63:0] o_top,
   output logic [63:0] o_bot
);
   logic [127:0] acc;
   // Unsigned math only; the pair stores whatever it is handed
   function automatic logic [127:0] calc(crfhl_resop_t op, logic [63:0] a, logic [63:0] b, logic [127:0] p);
      case (op)
         CRFHL_RES_MUL: calc = a * b;
         CRFHL_RES_MADD, CRFHL_RES_MACC: calc = p + a * b;
         CRFHL_RES_MSUB: calc = p - a * b;
         CRFHL_RES_DIV: calc = {a % b, a / b};
         CRFHL_RES_SETTOP: calc = {a, p[63:0]};
         CRFHL_RES_SETBOT: calc = {p[127:64], a};
         default: calc = p;
      endcase
   endfunction : calc
   assign {o_top, o_bot} = calc(i_op, i_a, i_b, acc);
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) acc <= '0;
      else if (i_ce) acc <= {o_top, o_bot};
   end
endmodule : crfhl_pipe_model
`default_nettype wire

// >>> bench/crfhl_regfile_tb.sv
// Self-checking bench for the register file and result pair
`timescale 1ns/10ps
`default_nettype none
module crfhl_regfile_tb import crfhl_pkg::*; ();
   logic clk = 0, rst = 1, ce = 0, cev = 1, we = 0, lk = 0, sg = 0;
   logic [4:0] wi = '0, ra = '0, rb = '0;
   crfhl_size_t sz = CRFHL_SZ_BYTE;
   crfhl_resop_t op = CRFHL_RES_NONE;
   logic [63:0] wd = '0, pb = '0, rda, rdb, top, bot, pt, pbt, mt = '0, mb = '0;
   logic [63:0] mdl [32] = '{default: '0};
   logic [63:0] exp_q [$];
   logic [2:0] look = '0, look_d = '0;
   int fails = 0, comparisons = 0, seed = 32'h0000_8977;
   crfhl_regfile DUT (.i_sys_clk(clk), .i_rst(rst), .i_ce(ce), .i_rd_a_idx(ra), .o_rd_a_data(rda),
      .i_rd_b_idx(rb), .o_rd_b_data(rdb), .i_wr_en(we), .i_wr_link(lk), .i_wr_idx(wi), .i_wr_size(sz),
      .i_wr_signed(sg), .i_wr_data(wd), .i_res_op(op), .i_res_top(pt), .i_res_bot(pbt),
      .o_result_top_word(top), .o_result_bottom_word(bot));
   crfhl_pipe_model u_pipe (.i_sys_clk(clk), .i_rst(rst), .i_ce(ce), .i_op(op), .i_a(wd), .i_b(pb),
      .o_top(pt), .o_bot(pbt));
   initial forever #10 clk = ~clk;
   function automatic logic [63:0] r64();
      return {$random(seed), $random(seed)};
   endfunction : r64
   // One call per edge, so no input is assigned twice in a time step
   task automatic cyc(input logic w, input logic l, input logic [4:0] i, input logic [1:0] s, input logic g,
      input logic [63:0] d, input logic [63:0] e, input logic [4:0] x, input logic [4:0] y,
      input logic [2:0] o, input logic [2:0] k);
      logic [63:0] v;
      @(posedge clk);
      {ce, we, lk, wi} <= {cev, w, l, i};
      sz <= crfhl_size_t'(s);
      {sg, wd, pb} <= {g, d, e | 64'h1};
      {ra, rb, look} <= {x, y, k & {3{cev}}};
      op <= crfhl_resop_t'(o);
      if (k[0] && cev) exp_q.push_back(mdl[x]);
      if (k[1] && cev) exp_q.push_back(mdl[y]);
      case (s)
         2'd0: v = g ? {{56{d[7]}}, d[7:0]} : {56'h0, d[7:0]};
         2'd1: v = g ? {{48{d[15]}}, d[15:0]} : {48'h0, d[15:0]};
         2'd2: v = {{32{d[31]}}, d[31:0]};
         default: v = d;
      endcase
      if (cev && w && (l || i != 5'h00)) mdl[l ? 5'h1f : i] = v;
      if (cev) {mt, mb} = u_pipe.calc(crfhl_resop_t'(o), d, e | 64'h1, {mt, mb});
      if (k[2] && cev) exp_q.push_back(mt);
      if (k[2] && cev) exp_q.push_back(mb);
   endtask : cyc
   task automatic chk(input string n, input logic [63:0] s);
      logic [63:0] e;
      e = exp_q.pop_front();
      comparisons++;
      if (s !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   always @(posedge clk) look_d <= look;
   always @(negedge clk) begin
      if (look_d[0]) chk("rd_a", rda);
      if (look_d[1]) chk("rd_b", rdb);
      if (look_d[2]) chk("top", top);
      if (look_d[2]) chk("bottom", bot);
   end
   task automatic end_of_test;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test
   initial begin
      #100000;
      fails++;
      end_of_test();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 0;
      cyc(0, 0, 0, 3, 0, '0, '0, 5, 31, 0, 7);
      // Same index read returns old value, previous index returns new
      for (int i = 0; i < 32; i++) cyc(1, 0, i, 3, 0, r64(), '0, i, i - 1, 0, 3);
      for (int i = 0; i < 32; i++) cyc(0, 0, 0, 3, 0, '0, '0, i, 31 - i, 0, 3);
      cyc(1, 1, 7, 3, 0, r64(), '0, 7, 31, 0, 3);
      cyc(0, 0, 0, 3, 0, '0, '0, 31, 7, 0, 3);
      for (int j = 0; j < 16; j++) begin
         cyc(1, 0, 3, j[1:0], j[2], j[3] ? r64() | 64'h8000_8080 : r64() & ~64'h8000_8080, '0, 3, 3, 0, 0);
         cyc(0, 0, 0, 3, 0, '0, '0, 3, 0, 0, 3);
      end
      for (int j = 0; j < 16; j++) cyc(0, 0, 0, 3, 0, r64(), r64(), 0, 0, j[2:0], 4);
      cev = 0;
      cyc(1, 0, 9, 3, 0, r64(), r64(), 9, 9, 1, 7);
      cev = 1;
      cyc(0, 0, 0, 3, 0, '0, '0, 9, 9, 0, 7);
      for (int j = 0; j < 60; j++) cyc($random(seed), $random(seed), $random(seed), $random(seed),
         $random(seed), r64(), r64(), $random(seed), $random(seed), $random(seed), 7);
      repeat (3) cyc(0, 0, 0, 3, 0, '0, '0, 0, 0, 0, 0);
      end_of_test();
   end
endmodule : crfhl_regfile_tb
`default_nettype wire
